// ### common/smp_map.svh
// register offsets, field positions, reset values and timing for the spi master port
`ifndef SMP_MAP_SVH
`define SMP_MAP_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define SMP_OFS_BUF 2'h0
`define SMP_OFS_CTL 2'h1
`define SMP_OFS_STAT 2'h2
// ----------------------------------------
// control register fields
// ----------------------------------------
`define SMP_CTL_WRITE_COLLISION_FLAG 7
`define SMP_CTL_EN 5
`define SMP_CTL_CKP 4
// ----------------------------------------
// status register fields
// ----------------------------------------
`define SMP_STAT_SMP 7
`define SMP_STAT_CKE 6
`define SMP_STAT_IRQ 1
`define SMP_STAT_BF 0
// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define SMP_CTL_RST 8'h00
`define SMP_STAT_RST 8'h00
`define SMP_BITS 4'h8
`define SMP_HALF_DIV4 6'h02
`define SMP_HALF_DIV16 6'h08
`define SMP_HALF_DIV64 6'h20
`endif

// ### common/smp_pkg.sv
// types for the spi master port
package smp_pkg;
  typedef enum logic [1:0] {
    SMP_IDLE = 2'b00,
    SMP_LEAD = 2'b01,
    SMP_TRAIL = 2'b10
  } smp_state_type;

  typedef struct packed {
    logic sck;
    logic serial_out_pin;
    logic sdo_oe;
    logic sck_oe;
  } smp_pins_type;
endpackage

// ### design/smp_master.sv
// spi master port: buffer, shift register, clock divider and register port
// Notes on behaviour
// R1 - every transfer swaps eight bits both ways, msb first
// R2 - after bit eight the byte lands in buffer, full and irq flags set
// R3 - buffer write during a transfer is dropped and sets write collision
// R4 - write collision stays set until software clears it
// R5 - software read of the buffer clears the full flag
// R6 - shift register has no address; reached only through the buffer
// R7 - enable plus master mode hands data and clock pins to the port
// R8 - clearing enable resets the port; new config applies on re-enable
// R9 - buffer write while idle starts a transfer at once
// R10 - input is sampled every transfer even when data out is unused
// R11 - clock rate is osc/4, osc/16, osc/64 or timer output/2
// R12 - serial clock polarity follows the polarity bit
// R13 - edge select set puts out each bit before its first clock edge
// R14 - sample bit picks middle or end of the output bit period
// R15 - sleep freezes all port clocks; transfer resumes on wake
// R16 - slave select is unused in master mode
// R17 - mode 0000 div4, 0001 div16, 0010 div64, 0011 timer/2
// R18 - polarity one idles clock high, zero idles low
// R19 - after a transfer the clock returns to idle level
// R20 - a completed transfer overwrites the buffer even if unread
`timescale 1ns/1ps
`default_nettype none
`include "smp_map.svh"
module smp_master
  import smp_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // register port
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // system
  input wire logic sleep_i,
  input wire logic tmr_tick_i,
  // serial pins
  input wire logic sdi_i,
  output logic sck_o,
  output logic sck_oe_o,
  output logic sdo_o,
  output logic sdo_oe_o
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] ctl_r;
  logic [7:0] stat_r;
  logic [7:0] buf_r;
  logic [7:0] sr_r;
  logic [3:0] cnt_r;
  logic [5:0] div_r;
  logic tmr_half_r;
  logic sdi_m_r;
  logic sdi_s_r;
  logic smp_bit_r;
  smp_state_type st_r;
  smp_pins_type pins_r;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire logic en = ctl_r[`SMP_CTL_EN];
  wire logic clock_polarity_bit = ctl_r[`SMP_CTL_CKP];
  wire logic [3:0] mode = ctl_r[3:0];
  wire logic master = (mode[3:2] == 2'b00); // R17
  wire logic active = en && master; // R7 R16
  wire logic busy = (st_r != SMP_IDLE);
  wire logic wr_buf = wr_i && (addr_i == `SMP_OFS_BUF); // R6
  wire logic rd_buf = rd_i && (addr_i == `SMP_OFS_BUF);
  wire logic wr_ctl = wr_i && (addr_i == `SMP_OFS_CTL);
  wire logic wr_stat = wr_i && (addr_i == `SMP_OFS_STAT);
  wire logic start = wr_buf && active && !busy; // R9
  wire logic coll = wr_buf && busy; // R3
  wire logic cke = stat_r[`SMP_STAT_CKE];
  wire logic smp = stat_r[`SMP_STAT_SMP];

  // half bit period select for the oscillator modes
  function automatic logic [5:0] half_of(input logic [1:0] m);
    unique case (m)
      2'b00: half_of = `SMP_HALF_DIV4; // R11
      2'b01: half_of = `SMP_HALF_DIV16;
      default: half_of = `SMP_HALF_DIV64;
    endcase
  endfunction

  // timer mode steps on each timer tick, giving timer/2 per bit
  wire logic tmr_mode = (mode[1:0] == 2'b11); // R11 R17
  wire logic div_done = (div_r == half_of(mode[1:0]) - 6'h01);
  wire logic step = !sleep_i && busy && (tmr_mode ? tmr_half_r : div_done); // R15
  wire logic last = (cnt_r == `SMP_BITS - 4'h1);
  wire logic [7:0] rx_byte = {sr_r[6:0], smp_bit_r};

  // ----------------------------------------
  // serial sequencing
  // ----------------------------------------
  // lead edge: sample (mid phase); trail edge: shift out next bit
  smp_state_type st_nxt;
  always_comb begin
    st_nxt = st_r;
    if (!active) begin
      st_nxt = SMP_IDLE; // R8
    end else if (start) begin
      st_nxt = SMP_LEAD;
    end else if (step) begin
      unique case (st_r)
        SMP_LEAD: st_nxt = SMP_TRAIL;
        SMP_TRAIL: st_nxt = last ? SMP_IDLE : SMP_LEAD; // R19
        default: st_nxt = SMP_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sdi_m_r <= 1'b0;
      sdi_s_r <= 1'b0;
      tmr_half_r <= 1'b0;
    end else begin
      sdi_m_r <= sdi_i;
      sdi_s_r <= sdi_m_r;
      tmr_half_r <= tmr_tick_i && !sleep_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= SMP_IDLE;
      div_r <= 6'h00;
      cnt_r <= 4'h0;
      sr_r <= 8'h00;
      smp_bit_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (!active || start || step) begin
        div_r <= 6'h00;
      end else if (busy && !sleep_i) begin
        div_r <= div_r + 6'h01; // R15
      end
      if (!active) begin
        cnt_r <= 4'h0; // R8
      end else if (start) begin
        cnt_r <= 4'h0;
        sr_r <= wdata_i; // R6 R9
      end else if (step && st_r == SMP_LEAD) begin
        if (!smp) begin
          smp_bit_r <= sdi_s_r; // R10 R14
        end
      end else if (step && st_r == SMP_TRAIL) begin
        sr_r <= {sr_r[6:0], smp ? sdi_s_r : smp_bit_r}; // R1 R14
        smp_bit_r <= 1'b0;
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  wire logic done = step && (st_r == SMP_TRAIL) && last;
  wire logic [7:0] done_byte = {sr_r[6:0], smp ? sdi_s_r : smp_bit_r};

  // ----------------------------------------
  // pins
  // ----------------------------------------
  // with cke clear the data changes on the first clock edge of the bit
  smp_pins_type pins_nxt;
  always_comb begin
    pins_nxt.sck_oe = active; // R7
    pins_nxt.sdo_oe = active;
    pins_nxt.sck = clock_polarity_bit ^ (st_nxt == SMP_TRAIL); // R12 R18 R19
    if (st_nxt == SMP_IDLE) begin
      pins_nxt.serial_out_pin = pins_r.serial_out_pin;
    end else if (start) begin
      pins_nxt.serial_out_pin = cke ? wdata_i[7] : pins_r.serial_out_pin; // R13
    end else if (!cke && st_nxt == SMP_TRAIL && st_r == SMP_LEAD) begin
      pins_nxt.serial_out_pin = sr_r[7];
    end else if (cke && st_nxt == SMP_LEAD && st_r == SMP_TRAIL) begin
      pins_nxt.serial_out_pin = sr_r[6]; // R13
    end else begin
      pins_nxt.serial_out_pin = pins_r.serial_out_pin;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pins_r <= '0;
    end else begin
      pins_r <= pins_nxt;
    end
  end

  assign sck_o = pins_r.sck;
  assign sck_oe_o = pins_r.sck_oe;
  assign sdo_o = pins_r.serial_out_pin;
  assign sdo_oe_o = pins_r.sdo_oe;

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctl_r <= `SMP_CTL_RST;
      stat_r <= `SMP_STAT_RST;
      buf_r <= 8'h00;
      rdata_o <= 8'h00;
    end else begin
      if (wr_ctl) begin
        ctl_r[6:0] <= wdata_i[6:0];
      end
      // set beats clear on the same cycle
      if (coll) begin
        ctl_r[`SMP_CTL_WRITE_COLLISION_FLAG] <= 1'b1; // R3 R4
      end else if (wr_ctl) begin
        ctl_r[`SMP_CTL_WRITE_COLLISION_FLAG] <= wdata_i[`SMP_CTL_WRITE_COLLISION_FLAG];
      end
      if (wr_stat) begin
        stat_r[7:6] <= wdata_i[7:6];
      end
      if (done) begin
        stat_r[`SMP_STAT_IRQ] <= 1'b1; // R2
      end else if (wr_stat && !wdata_i[`SMP_STAT_IRQ]) begin
        stat_r[`SMP_STAT_IRQ] <= 1'b0;
      end
      if (done) begin
        stat_r[`SMP_STAT_BF] <= 1'b1; // R2
      end else if (rd_buf) begin
        stat_r[`SMP_STAT_BF] <= 1'b0; // R5
      end
      if (done) begin
        buf_r <= done_byte; // R2 R20
      end else if (start) begin
        buf_r <= wdata_i;
      end
      unique case (addr_i)
        `SMP_OFS_BUF: rdata_o <= rd_i ? buf_r : 8'h00;
        `SMP_OFS_CTL: rdata_o <= rd_i ? ctl_r : 8'h00;
        `SMP_OFS_STAT: rdata_o <= rd_i ? stat_r : 8'h00;
        default: rdata_o <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_coll_sets_flag: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R3
    coll |=> ctl_r[`SMP_CTL_WRITE_COLLISION_FLAG])
    else $error("collision flag not set");
  a_done_sets_bf: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R2
    done |=> stat_r[`SMP_STAT_BF] && stat_r[`SMP_STAT_IRQ] && buf_r == $past(done_byte))
    else $error("completion flags wrong");
  a_read_clears_bf: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R5
    rd_buf && !done |=> !stat_r[`SMP_STAT_BF])
    else $error("buffer read left full flag");
  a_start_busy: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R9
    start |=> st_r == SMP_LEAD)
    else $error("write did not start transfer");
  a_idle_clock: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R18
    st_r == SMP_IDLE && $past(st_r) == SMP_IDLE && $stable(clock_polarity_bit) |-> sck_o == clock_polarity_bit)
    else $error("clock not at idle level");
  a_sleep_freeze: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R15
    sleep_i && active && !wr_i |=> $stable(cnt_r) && $stable(sr_r))
    else $error("transfer moved during sleep");
  a_disable_reset: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R8
    !active |=> st_r == SMP_IDLE && cnt_r == 4'h0)
    else $error("disable did not reset port");
  a_div4_rate: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R11
    start && mode == 4'h0 && !sleep_i ##1 !sleep_i [*2]
    |=> st_r == SMP_TRAIL || !active)
    else $error("divide by four rate wrong");
  a_pins_owned: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R7
    ##1 sck_oe_o == $past(active))
    else $error("pin ownership wrong");
endmodule // smp_master
`default_nettype wire

// ### test/smp_slave_model.sv
// spi slave model on the far side of the master port
`timescale 1ns/1ps
`default_nettype none
module smp_slave_model (
  // select and setup from the bench
  input wire logic cs_n_i,
  input wire logic ckp_i,
  input wire logic cke_i,
  input wire logic [7:0] tx_i,
  // serial pins
  input wire logic sck_i,
  input wire logic sdo_i,
  output logic sdi_o,
  output logic [7:0] rx_o
);
  logic [7:0] sh_r = 8'h00;
  logic last_r = 1'b0;
  always @(negedge cs_n_i) begin
    sh_r = tx_i;
    rx_o = 8'h00;
  end
  always @(posedge cs_n_i) last_r = sh_r[7];
  // capture mid bit, shift out when the clock returns to idle
  always @(sck_i) begin
    if (!cs_n_i && (sck_i != ckp_i) == cke_i) rx_o = {rx_o[6:0], sdo_i};
    if (!cs_n_i && sck_i == ckp_i) sh_r = {sh_r[6:0], 1'b0};
  end
  // deselected line shows the inverse of its last bit, never stale data
  assign sdi_o = cs_n_i ? ~last_r : sh_r[7];
endmodule // smp_slave_model
`default_nettype wire

// ### test/smp_master_test.sv
// self-checking bench for the spi master port
`timescale 1ns/1ps
`default_nettype none
`include "smp_map.svh"
module smp_master_test;
  localparam logic [1:0] AB = `SMP_OFS_BUF;
  localparam logic [1:0] AC = `SMP_OFS_CTL;
  localparam logic [1:0] AS = `SMP_OFS_STAT;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sleep = 1'b0;
  logic tick = 1'b0;
  logic cs_n = 1'b1;
  logic clock_polarity_bit = 1'b0;
  logic cke = 1'b0;
  logic [7:0] tx = 8'h00;
  logic [7:0] rdata, rx, got;
  logic serial_in_pin, sck, sck_oe, serial_out_pin, sdo_oe;
  logic [7:0] cc [6] = '{8'h20, 8'h31, 8'h22, 8'h33, 8'h21, 8'h30};
  logic [7:0] cs [6] = '{8'hc0, 8'h00, 8'h80, 8'h40, 8'h40, 8'h80};
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  smp_master i_dut (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .addr_i(addr),
    .wdata_i(wdata),
    .wr_i(wr),
    .rd_i(rd),
    .rdata_o(rdata),
    .sleep_i(sleep),
    .tmr_tick_i(tick),
    .sdi_i(serial_in_pin),
    .sck_o(sck),
    .sck_oe_o(sck_oe),
    .sdo_o(serial_out_pin),
    .sdo_oe_o(sdo_oe)
  );
  smp_slave_model i_slave (
    .cs_n_i(cs_n),
    .ckp_i(clock_polarity_bit),
    .cke_i(cke),
    .tx_i(tx),
    .sck_i(sck),
    .sdo_i(serial_out_pin),
    .sdi_o(serial_in_pin),
    .rx_o(rx)
  );
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  // timer output pulse every fourth cycle; also the hang limit
  always @(posedge mclk_i) begin
    cyc++;
    tick <= (cyc % 4 == 0);
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask
  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [1:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1 got = rdata;
    chk(got, e);
  endtask
  // one exchange, with a colliding write and an optional sleep pause
  task automatic xfer(input logic [7:0] c, s, d, t, input logic z);
    int n;
    clock_polarity_bit = c[`SMP_CTL_CKP];
    cke = s[`SMP_STAT_CKE];
    wreg(AC, c);
    wreg(AS, s);
    tx = t;
    cs_n <= 1'b0;
    wreg(AB, d);
    wreg(AB, ~d);
    if (z) begin
      sleep <= 1'b1;
      repeat (2) @(posedge mclk_i);
      #1 got[0] = sck;
      repeat (40) @(posedge mclk_i) #1 chkb(sck, got[0]);
      @(posedge mclk_i);
      sleep <= 1'b0;
    end
    n = 0;
    got = 8'h00;
    // full flag may still stand from the last byte; the irq flag was cleared above
    while (got[`SMP_STAT_IRQ] !== 1'b1 && n < 1000) begin
      rchk(AS, s | 8'h03);
      n++;
    end
    checked -= n - 1;
    n_mismatch -= n - 1;
    cs_n <= 1'b1;
    chkb(sck & sck_oe & sdo_oe, clock_polarity_bit & 1'b1);
    chk(rx, d);
    rchk(AC, c | 8'h80);
    wreg(AC, c);
  endtask
  initial begin
    repeat (20) @(posedge mclk_i);
    rstn_i <= 1'b1;
    #1 chkb(sck_oe | sdo_oe, 1'b0);
    rchk(AC, `SMP_CTL_RST);
    rchk(AS, `SMP_STAT_RST);
    rchk(AB, 8'h00);
    rchk(2'h3, 8'h00);
    for (int i = 0; i < 6; i++) begin
      xfer(cc[i], cs[i], 8'h96 ^ 8'(i), 8'h5a + 8'(i), 1'b0);
      xfer(cc[i], cs[i], 8'h69 + 8'(i), 8'ha5 ^ 8'(i), 1'b0);
      rchk(AB, 8'ha5 ^ 8'(i));
      rchk(AS, cs[i] | 8'h02);
      wreg(AS, cs[i]);
      rchk(AS, cs[i]);
      rchk(AC, cc[i]);
    end
    xfer(8'h21, 8'hc0, 8'hc3, 8'h3c, 1'b1);
    rchk(AB, 8'h3c);
    cs_n <= 1'b0;
    wreg(AB, 8'h81);
    repeat (20) @(posedge mclk_i);
    wreg(AC, 8'h01);
    cs_n <= 1'b1;
    wreg(AB, 8'h7e);
    rchk(AC, 8'h01);
    chkb(sck_oe | sdo_oe, 1'b0);
    xfer(8'h21, 8'h40, 8'h18, 8'he7, 1'b0);
    rchk(AB, 8'he7);
    wreg(AC, 8'h24);
    repeat (2) @(posedge mclk_i);
    #1 chkb(sck_oe | sdo_oe, 1'b0);
    wrap_up();
  end
endmodule // smp_master_test
`default_nettype wire
